// ### src/dlfmc_regs.vh
// register offsets, field positions, reset values and timing constants
`ifndef DLFMC_REGS_VH
`define DLFMC_REGS_VH

// register offsets
`define DLFMC_ENABLE_ADDR    8'h01
`define DLFMC_IVFM_ADDR      8'h02
`define DLFMC_FL1_ADDR       8'h03
`define DLFMC_FL2_ADDR       8'h04
`define DLFMC_TL1_ADDR       8'h05
`define DLFMC_TL2_ADDR       8'h06
`define DLFMC_BOOST_ADDR     8'h07
`define DLFMC_TIMING_ADDR    8'h08
`define DLFMC_TEMP_ADDR      8'h09
`define DLFMC_FLAGS1_ADDR    8'h0a
`define DLFMC_FLAGS2_ADDR    8'h0b

// enable register fields
`define DLFMC_EN_LED1        0
`define DLFMC_EN_LED2        1
`define DLFMC_EN_MODE_LO     2
`define DLFMC_EN_MODE_HI     3
`define DLFMC_EN_TORCH_PIN   4
`define DLFMC_EN_STROBE_PIN  5
`define DLFMC_EN_STROBE_EDGE 6
`define DLFMC_EN_TX          7

// mode field encodings
`define DLFMC_MODE_OFF       2'b00
`define DLFMC_MODE_TORCH     2'b10
`define DLFMC_MODE_FLASH     2'b11

// timing register fields
`define DLFMC_TIM_TO_LO      0
`define DLFMC_TIM_TO_HI      3
`define DLFMC_TIM_RAMP_LO    4
`define DLFMC_TIM_RAMP_HI    6

// temp register: pin function select, 0 = torch
`define DLFMC_TEMP_SEL       0

// boost register fields
`define DLFMC_BOOST_ILIM     0
`define DLFMC_BOOST_FSW      1

// flag bit positions
`define DLFMC_F1_TIMEOUT     0
`define DLFMC_F1_UVLO        1
`define DLFMC_F1_LED_FAULT   2
`define DLFMC_F1_CUR_LIMIT   3
`define DLFMC_F1_TSD         4
`define DLFMC_F2_OVER_TEMP   0
`define DLFMC_F2_TX_EVENT    1

// reset values
`define DLFMC_ENABLE_RST     8'h80
`define DLFMC_IVFM_RST       8'h01
`define DLFMC_FL_RST         8'h3f
`define DLFMC_TL_RST         8'h3f
`define DLFMC_BOOST_RST      8'h09
`define DLFMC_TIMING_RST     8'h1a
`define DLFMC_TEMP_RST       8'h08

// timing
`define DLFMC_CLK_NS         25
`define DLFMC_US_NS          1000
`define DLFMC_US_CYCLES      ((`DLFMC_US_NS + `DLFMC_CLK_NS - 1) / `DLFMC_CLK_NS)
`define DLFMC_MS_US          1000
`define DLFMC_RAMP_BASE_US   16
`define DLFMC_TO_BASE_MS     40
`define DLFMC_TO_KNEE_MS     400
`define DLFMC_TO_STEP_MS     200

`endif

// ### src/dlfmc_ramp.v
// one led current source with stepped ramp toward its target code
`timescale 1ns/1ps
module dlfmc_ramp #(
  parameter LW = 7
) (
  input  wire          clk_i,
  input  wire          sys_rst_i,
  input  wire          on_i,
  input  wire [LW-1:0] target_i,
  input  wire          step_i,
  output reg  [LW-1:0] level_o,
  output reg           on_o
);

  always @(posedge clk_i) begin
    if (sys_rst_i || !on_i) begin
      level_o <= {LW{1'b0}};
      on_o    <= 1'b0;
    end else begin
      on_o <= 1'b1;
      // one code per step, never skipping a level
      if (step_i) begin
        if (level_o < target_i) begin
          level_o <= level_o + {{(LW-1){1'b0}}, 1'b1};
        end else if (level_o > target_i) begin
          level_o <= level_o - {{(LW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ### src/dlfmc_top.v
// mode and enable control of a dual channel flash led driver
//
// Summary of operation
// - enable pin low: shutdown, registers at defaults
// - shutdown ignores every register access
// - enable pin high: standby, port accepts commands
// - flash: 128 levels per led register
// - flash from mode 11 or strobe pin
// - flash ramps through every current step
// - software flash: mode bits cleared on timeout
// - torch: 128 levels per led register
// - torch from mode 10 or torch pin
// - torch ramps at timing register rate
// - torch ignores timeout and sync input
// - shared pin defaults to torch function
// - flags report timeout, faults, sync, undervoltage
// - currents, timeout, current limit host adjustable
// - sync high in flash forces torch current
// - sync response off when enable bit7 zero
// - sixteen timeouts from 40 ms to 1.6 s
// - timeout clears mode, sets flag, read clears
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dlfmc_regs.vh"
module dlfmc_top #(
  parameter MS_US = `DLFMC_MS_US,
  parameter LW    = 7
) (
  input  wire          clk_i,
  input  wire          sys_rst_i,
  input  wire          hardware_enable_pin_i,
  input  wire          strobe_pin_i,
  input  wire          torch_temp_pin_i,
  input  wire          tx_pin_i,
  input  wire          uvlo_i,
  input  wire          thermal_sd_i,
  input  wire          led_fault_i,
  input  wire          ntc_trip_i,
  input  wire          cur_limit_i,
  input  wire [7:0]    addr_i,
  input  wire [7:0]    wr_data_i,
  input  wire          wr_i,
  input  wire          rd_i,
  output reg  [7:0]    rd_data_o,
  output reg           port_enabled_o,
  output reg           flash_active_o,
  output reg           torch_active_o,
  output reg           ilim_high_o,
  output reg           fsw_high_o,
  output wire [LW-1:0] led1_level_o,
  output wire [LW-1:0] led2_level_o,
  output wire          led1_on_o,
  output wire          led2_on_o
);

  localparam ST_STANDBY = 2'b00;
  localparam ST_FLASH   = 2'b01;
  localparam ST_TORCH   = 2'b10;

  // divider end points and boost defaults at explicit widths
  localparam [31:0] US_LAST   = `DLFMC_US_CYCLES - 1;
  localparam [31:0] MS_LAST   = MS_US - 1;
  localparam [7:0]  BOOST_DEF = `DLFMC_BOOST_RST;

  // flash timeout table in ms
  function [10:0] timeout_ms;
    input [3:0] sel;
    integer t;
    begin
      if (sel < 4'd10) begin
        t = `DLFMC_TO_BASE_MS * (sel + 1);
      end else begin
        t = `DLFMC_TO_KNEE_MS + `DLFMC_TO_STEP_MS * (sel - 9);
      end
      timeout_ms = t[10:0];
    end
  endfunction

  // torch step period in us
  function [11:0] ramp_period_us;
    input [2:0] sel;
    integer t;
    begin
      t = `DLFMC_RAMP_BASE_US << sel;
      ramp_period_us = t[11:0];
    end
  endfunction

  // two-flop synchronisers for every pin
  reg  [9:0] in_meta;
  reg  [9:0] in_sync;
  reg        strobe_prev;

  wire hardware_enable_pin_s      = in_sync[0];
  wire strobe_s    = in_sync[1];
  wire torch_s     = in_sync[2];
  wire tx_s        = in_sync[3];
  wire uvlo_s      = in_sync[4];
  wire tsd_s       = in_sync[5];
  wire led_fault_s = in_sync[6];
  wire ntc_s       = in_sync[7];
  wire ilim_s      = in_sync[8];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_meta     <= 10'h000;
      in_sync     <= 10'h000;
      strobe_prev <= 1'b0;
    end else begin
      in_meta     <= {1'b0, cur_limit_i, ntc_trip_i, led_fault_i, thermal_sd_i,
                      uvlo_i, tx_pin_i, torch_temp_pin_i, strobe_pin_i,
                      hardware_enable_pin_i};
      in_sync     <= in_meta;
      strobe_prev <= in_sync[1];
    end
  end

  // registers
  reg  [7:0] en_reg;
  reg  [7:0] ivfm_reg;
  reg  [7:0] fl1_reg;
  reg  [7:0] fl2_reg;
  reg  [7:0] tl1_reg;
  reg  [7:0] tl2_reg;
  reg  [7:0] timing_reg;
  reg  [7:0] temp_reg;
  reg  [7:0] flags1;
  reg  [7:0] flags2;
  reg  [7:0] next_flags1;
  reg  [7:0] next_flags2;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [10:0] to_cnt;
  reg        strobe_block;
  reg  [5:0] us_cnt;
  reg        us_tick;
  reg  [15:0] ms_cnt;
  reg        ms_tick;
  reg  [11:0] tr_cnt;
  reg        torch_step;

  wire       dev_on     = hardware_enable_pin_s;
  wire       wr_ok      = wr_i && dev_on;
  wire       rd_ok      = rd_i && dev_on;
  wire [1:0] mode_field = en_reg[`DLFMC_EN_MODE_HI:`DLFMC_EN_MODE_LO];
  wire       strobe_rise = strobe_s && !strobe_prev;
  wire       edge_type  = en_reg[`DLFMC_EN_STROBE_EDGE];

  // flash request by mode field or enabled strobe pin
  wire sw_flash  = (mode_field == `DLFMC_MODE_FLASH);
  wire pin_flash = en_reg[`DLFMC_EN_STROBE_PIN] &&
                   (edge_type ? strobe_rise : (strobe_s && !strobe_block));
  wire hold_pin  = en_reg[`DLFMC_EN_STROBE_PIN] && (edge_type || strobe_s);
  // torch request: mode field or torch pin in torch function
  wire torch_req = (mode_field == `DLFMC_MODE_TORCH) ||
                   (en_reg[`DLFMC_EN_TORCH_PIN] && !temp_reg[`DLFMC_TEMP_SEL] &&
                    torch_s);
  wire fault_stop = uvlo_s || tsd_s;
  wire tx_cut     = en_reg[`DLFMC_EN_TX] && tx_s;

  wire [10:0] to_limit =
    timeout_ms(timing_reg[`DLFMC_TIM_TO_HI:`DLFMC_TIM_TO_LO]);
  wire timeout_evt = (state == ST_FLASH) && ms_tick &&
                     (to_cnt == to_limit - 11'd1);

  // register writes; shutdown holds defaults
  always @(posedge clk_i) begin
    if (sys_rst_i || !dev_on) begin
      en_reg     <= `DLFMC_ENABLE_RST;
      ivfm_reg   <= `DLFMC_IVFM_RST;
      fl1_reg    <= `DLFMC_FL_RST;
      fl2_reg    <= `DLFMC_FL_RST;
      tl1_reg    <= `DLFMC_TL_RST;
      tl2_reg    <= `DLFMC_TL_RST;
      timing_reg <= `DLFMC_TIMING_RST;
      temp_reg   <= `DLFMC_TEMP_RST;
      ilim_high_o <= BOOST_DEF[`DLFMC_BOOST_ILIM];
      fsw_high_o  <= BOOST_DEF[`DLFMC_BOOST_FSW];
    end else begin
      if (wr_ok) begin
        case (addr_i)
          `DLFMC_ENABLE_ADDR: begin
            en_reg <= wr_data_i;
          end
          `DLFMC_IVFM_ADDR: begin
            ivfm_reg <= wr_data_i;
          end
          `DLFMC_FL1_ADDR: begin
            fl1_reg <= wr_data_i;
          end
          `DLFMC_FL2_ADDR: begin
            fl2_reg <= wr_data_i;
          end
          `DLFMC_TL1_ADDR: begin
            tl1_reg <= wr_data_i;
          end
          `DLFMC_TL2_ADDR: begin
            tl2_reg <= wr_data_i;
          end
          `DLFMC_BOOST_ADDR: begin
            ilim_high_o <= wr_data_i[`DLFMC_BOOST_ILIM];
            fsw_high_o  <= wr_data_i[`DLFMC_BOOST_FSW];
          end
          `DLFMC_TIMING_ADDR: begin
            timing_reg <= wr_data_i;
          end
          `DLFMC_TEMP_ADDR: begin
            temp_reg <= wr_data_i;
          end
          default: begin
          end
        endcase
      end
      // timeout clears the mode field, over a same-cycle write
      if (timeout_evt) begin
        en_reg[`DLFMC_EN_MODE_HI:`DLFMC_EN_MODE_LO] <= `DLFMC_MODE_OFF;
      end
    end
  end

  // flags: set wins over read clear
  always @* begin
    next_flags1 = flags1;
    next_flags2 = flags2;
    if (rd_ok && addr_i == `DLFMC_FLAGS1_ADDR) begin
      next_flags1 = 8'h00;
    end
    if (rd_ok && addr_i == `DLFMC_FLAGS2_ADDR) begin
      next_flags2 = 8'h00;
    end
    if (timeout_evt) begin
      next_flags1[`DLFMC_F1_TIMEOUT] = 1'b1;
    end
    if (uvlo_s) begin
      next_flags1[`DLFMC_F1_UVLO] = 1'b1;
    end
    if (led_fault_s) begin
      next_flags1[`DLFMC_F1_LED_FAULT] = 1'b1;
    end
    if (ilim_s) begin
      next_flags1[`DLFMC_F1_CUR_LIMIT] = 1'b1;
    end
    if (tsd_s) begin
      next_flags1[`DLFMC_F1_TSD] = 1'b1;
    end
    if (ntc_s && temp_reg[`DLFMC_TEMP_SEL]) begin
      next_flags2[`DLFMC_F2_OVER_TEMP] = 1'b1;
    end
    if (tx_cut && state == ST_FLASH) begin
      next_flags2[`DLFMC_F2_TX_EVENT] = 1'b1;
    end
  end

  // flags and read port
  always @(posedge clk_i) begin
    if (sys_rst_i || !dev_on) begin
      flags1         <= 8'h00;
      flags2         <= 8'h00;
      rd_data_o      <= 8'h00;
      port_enabled_o <= 1'b0;
    end else begin
      flags1         <= next_flags1;
      flags2         <= next_flags2;
      port_enabled_o <= 1'b1;
      rd_data_o      <= 8'h00;
      if (rd_ok) begin
        case (addr_i)
          `DLFMC_ENABLE_ADDR: begin
            rd_data_o <= en_reg;
          end
          `DLFMC_IVFM_ADDR: begin
            rd_data_o <= ivfm_reg;
          end
          `DLFMC_FL1_ADDR: begin
            rd_data_o <= fl1_reg;
          end
          `DLFMC_FL2_ADDR: begin
            rd_data_o <= fl2_reg;
          end
          `DLFMC_TL1_ADDR: begin
            rd_data_o <= tl1_reg;
          end
          `DLFMC_TL2_ADDR: begin
            rd_data_o <= tl2_reg;
          end
          `DLFMC_BOOST_ADDR: begin
            rd_data_o <= {6'h00, fsw_high_o, ilim_high_o};
          end
          `DLFMC_TIMING_ADDR: begin
            rd_data_o <= timing_reg;
          end
          `DLFMC_TEMP_ADDR: begin
            rd_data_o <= temp_reg;
          end
          `DLFMC_FLAGS1_ADDR: begin
            rd_data_o <= flags1;
          end
          `DLFMC_FLAGS2_ADDR: begin
            rd_data_o <= flags2;
          end
          default: begin
            rd_data_o <= 8'h00;
          end
        endcase
      end
    end
  end

  // us and ms enable pulses, torch step pulse
  always @(posedge clk_i) begin
    if (sys_rst_i || !dev_on) begin
      us_cnt     <= 6'h00;
      us_tick    <= 1'b0;
      ms_cnt     <= 16'h0000;
      ms_tick    <= 1'b0;
      tr_cnt     <= 12'h000;
      torch_step <= 1'b0;
    end else begin
      us_tick    <= 1'b0;
      ms_tick    <= 1'b0;
      torch_step <= 1'b0;
      if (us_cnt == US_LAST[5:0]) begin
        us_cnt  <= 6'h00;
        us_tick <= 1'b1;
      end else begin
        us_cnt <= us_cnt + 6'h01;
      end
      if (state != ST_FLASH) begin
        ms_cnt <= 16'h0000;
      end else if (us_tick) begin
        if (ms_cnt == MS_LAST[15:0]) begin
          ms_cnt  <= 16'h0000;
          ms_tick <= 1'b1;
        end else begin
          ms_cnt <= ms_cnt + 16'h0001;
        end
      end
      if (state != ST_TORCH) begin
        tr_cnt <= 12'h000;
      end else if (us_tick) begin
        if (tr_cnt >= ramp_period_us(timing_reg[`DLFMC_TIM_RAMP_HI:`DLFMC_TIM_RAMP_LO])
                      - 12'h001) begin
          tr_cnt     <= 12'h000;
          torch_step <= 1'b1;
        end else begin
          tr_cnt <= tr_cnt + 12'h001;
        end
      end
    end
  end

  // mode selection
  always @* begin
    next_state = state;
    case (state)
      ST_STANDBY: begin
        if (fault_stop) begin
          next_state = ST_STANDBY;
        end else if (sw_flash || pin_flash) begin
          next_state = ST_FLASH;
        end else if (torch_req) begin
          next_state = ST_TORCH;
        end else begin
          next_state = ST_STANDBY;
        end
      end
      ST_FLASH: begin
        if (fault_stop || timeout_evt) begin
          next_state = ST_STANDBY;
        end else if (!sw_flash && !hold_pin) begin
          next_state = torch_req ? ST_TORCH : ST_STANDBY;
        end
      end
      ST_TORCH: begin
        // no timeout or sync input here
        if (fault_stop) begin
          next_state = ST_STANDBY;
        end else if (sw_flash || pin_flash) begin
          next_state = ST_FLASH;
        end else if (!torch_req) begin
          next_state = ST_STANDBY;
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (sys_rst_i || !dev_on) begin
      state          <= ST_STANDBY;
      to_cnt         <= 11'h000;
      strobe_block   <= 1'b0;
      flash_active_o <= 1'b0;
      torch_active_o <= 1'b0;
    end else begin
      state          <= next_state;
      flash_active_o <= (next_state == ST_FLASH);
      torch_active_o <= (next_state == ST_TORCH);
      if (state != ST_FLASH) begin
        to_cnt <= 11'h000;
      end else if (ms_tick) begin
        to_cnt <= to_cnt + 11'h001;
      end
      // a held level strobe must drop before another flash
      if (timeout_evt) begin
        strobe_block <= 1'b1;
      end else if (!strobe_s) begin
        strobe_block <= 1'b0;
      end
    end
  end

  // targets: flash level, or torch level in torch or under sync
  wire           flash_cur = (state == ST_FLASH) && !tx_cut;
  wire [LW-1:0]  tgt1 = flash_cur ? fl1_reg[LW-1:0] : tl1_reg[LW-1:0];
  wire [LW-1:0]  tgt2 = flash_cur ? fl2_reg[LW-1:0] : tl2_reg[LW-1:0];
  wire           lit  = (state != ST_STANDBY);
  wire           step = (state == ST_FLASH) ? us_tick : torch_step;

  dlfmc_ramp #(
    .LW (LW)
  ) u_led1 (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .on_i      (lit && en_reg[`DLFMC_EN_LED1]),
    .target_i  (tgt1),
    .step_i    (step),
    .level_o   (led1_level_o),
    .on_o      (led1_on_o)
  );

  dlfmc_ramp #(
    .LW (LW)
  ) u_led2 (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .on_i      (lit && en_reg[`DLFMC_EN_LED2]),
    .target_i  (tgt2),
    .step_i    (step),
    .level_o   (led2_level_o),
    .on_o      (led2_on_o)
  );

endmodule

// ### verif/dlfmc_top_sva.sv
// assertion checker for the mode control top, bound to its ports
`timescale 1ns/1ps
module dlfmc_top_sva #(
  parameter LW = 7
) (
  input wire          clk_i,
  input wire          sys_rst_i,
  input wire          hardware_enable_pin_i,
  input wire          rd_i,
  input wire [7:0]    rd_data_o,
  input wire          port_enabled_o,
  input wire          flash_active_o,
  input wire          torch_active_o,
  input wire          ilim_high_o,
  input wire          fsw_high_o,
  input wire [LW-1:0] led1_level_o,
  input wire [LW-1:0] led2_level_o,
  input wire          led1_on_o,
  input wire          led2_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_hw_low;
    !hardware_enable_pin_i [*4];
  endsequence
  sequence s_hw_high;
    hardware_enable_pin_i [*5];
  endsequence
  sequence s_idle;
    (!flash_active_o && !torch_active_o) [*3];
  endsequence
  a_port_off_low: assert property (s_hw_low |=> !port_enabled_o)
    else $error("port open while enable pin low");
  a_port_on_high: assert property (s_hw_high |=> port_enabled_o)
    else $error("port closed while enable pin high");
  a_shut_read_silent: assert property (s_hw_low ##0 rd_i |=> rd_data_o == 8'h00)
    else $error("read answered in shutdown");
  a_rd_data_window: assert property (rd_data_o != 8'h00 |-> $past(rd_i))
    else $error("read data outside its cycle");
  a_boost_default: assert property ($rose(port_enabled_o) |-> ilim_high_o && !fsw_high_o)
    else $error("boost settings not at default on wake");
  a_standby_dark: assert property (s_idle |=> !led1_on_o && !led2_on_o)
    else $error("led source on in standby");
  a_led1_one_step: assert property (led1_on_o && $past(led1_on_o)
    && (led1_level_o > $past(led1_level_o)) |-> led1_level_o == $past(led1_level_o) + 1'b1)
    else $error("led1 skipped a current step");
  a_led2_one_step: assert property (led2_on_o && $past(led2_on_o)
    && (led2_level_o > $past(led2_level_o)) |-> led2_level_o == $past(led2_level_o) + 1'b1)
    else $error("led2 skipped a current step");
  a_torch_no_drop: assert property (torch_active_o && $past(torch_active_o) && led1_on_o
    && $past(led1_on_o) |-> led1_level_o >= $past(led1_level_o))
    else $error("torch current dropped");
endmodule

bind dlfmc_top dlfmc_top_sva #(.LW(LW)) dlfmc_top_sva_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hardware_enable_pin_i(hardware_enable_pin_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .port_enabled_o(port_enabled_o),
  .flash_active_o(flash_active_o), .torch_active_o(torch_active_o),
  .ilim_high_o(ilim_high_o), .fsw_high_o(fsw_high_o), .led1_level_o(led1_level_o),
  .led2_level_o(led2_level_o), .led1_on_o(led1_on_o), .led2_on_o(led2_on_o));

// ### verif/dlfmc_host.sv
// host model: register port master and pin driver
`timescale 1ns/1ps
module dlfmc_host #(
  parameter WAIT_CYCLES = 80000
) (
  input  wire       clk_i,
  input  wire [7:0] rd_data_i,
  output reg        hw_en_o  = 1'b0,
  output reg        strobe_o = 1'b0,
  output reg        torch_o  = 1'b0,
  output reg        tx_o     = 1'b0,
  output reg  [7:0] addr_o   = 8'h00,
  output reg  [7:0] wdata_o  = 8'h00,
  output reg        wr_o     = 1'b0,
  output reg        rd_o     = 1'b0
);
  task power_up;
    begin
      @(posedge clk_i);
      hw_en_o <= 1'b1;
      repeat (WAIT_CYCLES) @(posedge clk_i);
    end
  endtask
  task power_down;
    begin
      @(posedge clk_i);
      hw_en_o <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask
  task pins(input s, input t, input x);
    begin
      @(posedge clk_i);
      strobe_o <= s;
      torch_o  <= t;
      tx_o     <= x;
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
    end
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(negedge clk_i);
      d = rd_data_i;
    end
  endtask
endmodule

// ### verif/dlfmc_top_tb.sv
// self-checking bench of the mode control top
`timescale 1ns/1ps
`include "dlfmc_regs.vh"
module dlfmc_top_tb;
  reg        clk_i     = 1'b0;
  reg        sys_rst_i = 1'b1;
  reg        cur_lim   = 1'b0;
  reg        uvlo      = 1'b0;
  reg        led_flt   = 1'b0;
  wire       hw_en, strobe, torch, tx, wr, rd_st, port_en, fl_act, to_act, ilim, fsw, on1, on2;
  wire [7:0] addr, wdata, rdata;
  wire [6:0] lvl1, lvl2;
  reg  [7:0] rdv;
  integer    err_count  = 0;
  integer    n_compared = 0;
  integer    cycles     = 0;
  integer    k;
  always #12.5 clk_i = ~clk_i;
  dlfmc_host #(.WAIT_CYCLES(160)) dlfmc_host_i (.clk_i(clk_i), .rd_data_i(rdata),
    .hw_en_o(hw_en), .strobe_o(strobe), .torch_o(torch), .tx_o(tx), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd_st));
  dlfmc_top #(.MS_US(2), .LW(7)) dlfmc_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .hardware_enable_pin_i(hw_en), .strobe_pin_i(strobe), .torch_temp_pin_i(torch),
    .tx_pin_i(tx), .uvlo_i(uvlo), .thermal_sd_i(1'b0), .led_fault_i(led_flt),
    .ntc_trip_i(1'b0), .cur_limit_i(cur_lim), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
    .rd_i(rd_st), .rd_data_o(rdata), .port_enabled_o(port_en), .flash_active_o(fl_act),
    .torch_active_o(to_act), .ilim_high_o(ilim), .fsw_high_o(fsw), .led1_level_o(lvl1),
    .led2_level_o(lvl2), .led1_on_o(on1), .led2_on_o(on2));
  task report_and_stop;
    begin
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        err_count = err_count + 1;
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input string what);
    begin
      dlfmc_host_i.rd_reg(a, rdv);
      chk(what, exp, rdv);
    end
  endtask
  task wait_lvl(input [6:0] lv, input integer max);
    begin
      for (k = 0; k < max && lvl1 !== lv; k = k + 1) @(posedge clk_i);
      @(negedge clk_i);
      chk("led1 level", {1'b0, lv}, {1'b0, lvl1});
    end
  endtask
  task end_flash;
    begin
      for (k = 0; k < 4000 && fl_act !== 1'b0; k = k + 1) @(posedge clk_i);
      dlfmc_host_i.rd_reg(`DLFMC_FLAGS1_ADDR, rdv);
    end
  endtask
  task t_defaults;
    begin
      rd(`DLFMC_ENABLE_ADDR, 8'h80, "enable default");
      rd(`DLFMC_TIMING_ADDR, 8'h1a, "timing default");
      rd(`DLFMC_TEMP_ADDR, 8'h08, "temp default");
      rd(`DLFMC_FL1_ADDR, 8'h3f, "flash1 default");
      rd(`DLFMC_TL2_ADDR, 8'h3f, "torch2 default");
      rd(8'h20, 8'h00, "unmapped read");
      chk("ilim default", 8'h01, {7'h0, ilim});
      chk("fsw default", 8'h00, {7'h0, fsw});
    end
  endtask
  task t_shutdown;
    begin
      dlfmc_host_i.wr_reg(`DLFMC_BOOST_ADDR, 8'h0a);
      @(negedge clk_i);
      chk("ilim written", 8'h00, {7'h0, ilim});
      chk("fsw written", 8'h01, {7'h0, fsw});
      rd(`DLFMC_BOOST_ADDR, 8'h02, "boost readback");
      dlfmc_host_i.wr_reg(`DLFMC_FL1_ADDR, 8'h11);
      dlfmc_host_i.power_down;
      chk("port off", 8'h00, {7'h0, port_en});
      dlfmc_host_i.wr_reg(`DLFMC_FL1_ADDR, 8'h05);
      rd(`DLFMC_FL1_ADDR, 8'h00, "shutdown read");
      dlfmc_host_i.power_up;
      chk("port on", 8'h01, {7'h0, port_en});
      chk("ilim restored", 8'h01, {7'h0, ilim});
      chk("fsw restored", 8'h00, {7'h0, fsw});
      rd(`DLFMC_FL1_ADDR, 8'h3f, "flash1 after wake");
    end
  endtask
  task t_flash_sw;
    begin
      dlfmc_host_i.wr_reg(`DLFMC_FL1_ADDR, 8'h05);
      dlfmc_host_i.wr_reg(`DLFMC_FL2_ADDR, 8'h03);
      dlfmc_host_i.wr_reg(`DLFMC_TIMING_ADDR, 8'h00);
      dlfmc_host_i.wr_reg(`DLFMC_ENABLE_ADDR, 8'h8f);
      wait_lvl(7'h05, 600);
      chk("led2 level", 8'h03, {1'b0, lvl2});
      chk("flash on", 8'h01, {7'h0, fl_act});
      end_flash;
      chk("timeout length", 8'h01, {7'h0, k > 2800});
      chk("timeout flag", 8'h01, rdv & 8'h01);
      rd(`DLFMC_FLAGS1_ADDR, 8'h00, "flag after read");
      rd(`DLFMC_ENABLE_ADDR, 8'h83, "mode cleared");
      chk("leds off", 8'h00, {6'h0, on1, on2});
    end
  endtask
  task t_tx;
    begin
      dlfmc_host_i.wr_reg(`DLFMC_TL1_ADDR, 8'h02);
      dlfmc_host_i.wr_reg(`DLFMC_FL1_ADDR, 8'h06);
      dlfmc_host_i.wr_reg(`DLFMC_ENABLE_ADDR, 8'h8d);
      wait_lvl(7'h06, 600);
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b1);
      wait_lvl(7'h02, 600);
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b0);
      wait_lvl(7'h06, 600);
      end_flash;
      rd(`DLFMC_FLAGS2_ADDR, 8'h02, "sync event flag");
      dlfmc_host_i.wr_reg(`DLFMC_ENABLE_ADDR, 8'h0d);
      wait_lvl(7'h06, 600);
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b1);
      repeat (400) @(posedge clk_i);
      chk("tx disabled", 8'h06, {1'b0, lvl1});
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b0);
      end_flash;
    end
  endtask
  task t_torch;
    begin
      dlfmc_host_i.wr_reg(`DLFMC_TL1_ADDR, 8'h03);
      dlfmc_host_i.wr_reg(`DLFMC_ENABLE_ADDR, 8'h89);
      wait_lvl(7'h03, 3000);
      chk("torch ramp rate", 8'h01, {7'h0, k > 1200});
      chk("torch on", 8'h01, {7'h0, to_act});
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b1);
      repeat (4000) @(posedge clk_i);
      chk("torch held", 8'h83, {to_act, lvl1});
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b0);
      dlfmc_host_i.wr_reg(`DLFMC_ENABLE_ADDR, 8'h80);
      repeat (10) @(posedge clk_i);
      chk("standby dark", 8'h00, {6'h0, on1, to_act});
    end
  endtask
  task t_pins;
    begin
      dlfmc_host_i.wr_reg(`DLFMC_ENABLE_ADDR, 8'ha1);
      dlfmc_host_i.pins(1'b1, 1'b0, 1'b0);
      repeat (8) @(posedge clk_i);
      chk("strobe flash", 8'h01, {7'h0, fl_act});
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b0);
      repeat (8) @(posedge clk_i);
      dlfmc_host_i.wr_reg(`DLFMC_ENABLE_ADDR, 8'h91);
      dlfmc_host_i.pins(1'b0, 1'b1, 1'b0);
      repeat (8) @(posedge clk_i);
      chk("torch pin", 8'h02, {to_act, fl_act});
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b0);
      dlfmc_host_i.wr_reg(`DLFMC_TEMP_ADDR, 8'h09);
      dlfmc_host_i.pins(1'b0, 1'b1, 1'b0);
      repeat (8) @(posedge clk_i);
      chk("thermistor mode", 8'h00, {7'h0, to_act});
      dlfmc_host_i.pins(1'b0, 1'b0, 1'b0);
    end
  endtask
  task t_flags;
    begin
      @(posedge clk_i);
      cur_lim <= 1'b1;
      uvlo    <= 1'b1;
      led_flt <= 1'b1;
      repeat (4) @(posedge clk_i);
      cur_lim <= 1'b0;
      uvlo    <= 1'b0;
      led_flt <= 1'b0;
      dlfmc_host_i.wr_reg(`DLFMC_FLAGS1_ADDR, 8'h00);
      dlfmc_host_i.rd_reg(`DLFMC_FLAGS1_ADDR, rdv);
      chk("limit flag", 8'h08, rdv & 8'h08);
      chk("fault flags", 8'h06, rdv & 8'h06);
      rd(`DLFMC_FLAGS1_ADDR, 8'h00, "limit flag cleared");
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    dlfmc_host_i.power_up;
    t_defaults;
    t_shutdown;
    t_flash_sw;
    t_tx;
    t_torch;
    t_pins;
    t_flags;
    report_and_stop;
  end
endmodule
